// ---- core/ccs_defs.vh ----
// Constants for the cycle sequencer core
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH
`define CCS_PULSES_PER_CYCLE 4'h8
`define CCS_LAST_PULSE       3'h7
`define CCS_ST_IDLE          2'h0
`define CCS_ST_FETCH         2'h1
`define CCS_ST_EXEC          2'h2
`define CCS_ST_DMA           2'h3
`define CCS_INT_PTR_SEL      4'h2
`define CCS_INT_PC_SEL       4'h1
`define CCS_DMA_REG          4'h0
`define CCS_OP_IDLE          4'h0
`define CCS_OP_INC           4'h1
`define CCS_OP_DEC           4'h2
`define CCS_OP_BRANCH        4'h3
`define CCS_OP_LOAD          4'h4
`define CCS_OP_STORE         4'h5
`define CCS_OP_IO            4'h6
`define CCS_OP_CTRL          4'h7
`define CCS_OP_GLO           4'h8
`define CCS_OP_GHI           4'h9
`define CCS_OP_PLO           4'hA
`define CCS_OP_PHI           4'hB
`define CCS_OP_SETPC         4'hD
`define CCS_OP_SETPTR        4'hE
`define CCS_OP_ALU           4'hF
`define CCS_SAVE_CODE        4'h8
// Write strobe spans pulses 5..6 plus a half, approximated as 2 pulses
`define CCS_WR_FIRST         3'h5
`define CCS_WR_LAST          3'h6
`define CCS_ADDR_HI_PULSES   3'h2
`endif

// ---- core/ccs_reg_array.v ----
// Sixteen 16-bit pointer registers with one write port
`timescale 1ns/1ps
module ccs_reg_array (
  input  wire        mclk_in,
  input  wire        resetn_in,
  input  wire [3:0]  rd_sel_in,
  input  wire [3:0]  wr_sel_in,
  input  wire        wr_en_in,
  input  wire [15:0] wr_data_in,
  output wire [15:0] rd_data_out
);
  reg [15:0] regs [0:15];
  integer    i;

  assign rd_data_out = regs[rd_sel_in];

  // Register zero clears on reset so a DMA load starts at address 0000
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (i = 0; i < 16; i = i + 1) begin
        regs[i] <= 16'h0000;
      end
    end else if (wr_en_in) begin
      regs[wr_sel_in] <= wr_data_in;
    end
  end
endmodule

// ---- core/ccs_sequencer.v ----
// Fetch/execute machine-cycle sequencer for an 8-bit register processor
`timescale 1ns/1ps
`include "ccs_defs.vh"
// Contract
// - Each instruction is one fetch then one execute cycle, eight pulses each.
// - Fetch addresses via pc_selector; byte splits into high and low nibbles.
// - Program counter register advances by one after each instruction fetch.
// - Sixteen 16-bit registers, selected by low nibble, pc or pointer selector.
// - Addresses go out on eight lines, upper byte first then lower.
// - One cycle may address, move a byte to accumulator and step register.
// - ALU F0-F7, output 61-67, input 69-6F address through pointer_selector.
// - Load 4N and store 5N address through the low-nibble register.
// - Immediate ALU F8-FF fetch operand through program counter register.
// - DMA request waits for the end of an execute, DMA or idle cycle, then one stolen cycle runs.
// - Stolen cycle addresses via register zero, then increments it.
// - DMA beats a concurrent interrupt request.
// - Interrupt taken only when enabled, and only at the end of an execute, DMA or idle cycle.
// - Interrupt entry saves selectors, sets pointer 2, pc 1, clears enable.
// - Saved byte holds pointer selector high, pc selector low.
// - Code 78 writes saved byte to memory at pointer register.
// - All state static; halting the clock loses nothing.
// - One instruction can load pc_selector, switching program counter.
// - I/O instructions present the low nibble to peripherals.
// - Write strobe stands two clock periods, pulses 5 and 6.
// - Accumulator is 8 bits; carry flag is one bit of ALU carry.
// - Clear gives idle cycles, pc_selector zero, register zero 0000, enable set.
module ccs_sequencer (
  input  wire       mclk_in,
  input  wire       resetn_in,
  input  wire [7:0] data_in,
  input  wire       dma_in_req_in,
  input  wire       dma_out_req_in,
  input  wire       int_req_in,
  input  wire [3:0] ext_flags_in,
  output reg  [7:0] addr_out,
  output reg  [7:0] data_out,
  output wire       data_oe_out,
  output wire       memory_write_strobe_out,
  output wire       mem_read_out,
  output reg  [3:0] io_cmd_out,
  output wire       io_active_out,
  output wire       dma_ack_out,
  output wire       int_ack_out,
  output wire [1:0] cycle_state_out,
  output wire [2:0] pulse_out,
  output wire [7:0] accumulator_out,
  output wire       carry_flag_out,
  output wire       interrupt_enable_flag_out,
  output wire [7:0] saved_context_byte_out
);
  localparam ST_IDLE  = `CCS_ST_IDLE;
  localparam ST_FETCH = `CCS_ST_FETCH;
  localparam ST_EXEC  = `CCS_ST_EXEC;
  localparam ST_DMA   = `CCS_ST_DMA;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] pulse;
  reg [3:0] high_opcode_nibble;
  reg [3:0] low_opcode_nibble;
  reg [3:0] pc_selector;
  reg [3:0] pointer_selector;
  reg [7:0] accumulator;
  reg       carry_flag;
  reg       interrupt_enable_flag;
  reg [7:0] saved_context_byte;
  reg       dma_dir_in;
  reg       int_taken;

  reg  [3:0]  rd_sel;
  reg         wr_en;
  reg  [15:0] wr_data;
  reg         mem_wr;
  reg         mem_rd;
  wire [15:0] sel_reg;
  wire        last_pulse = (pulse == `CCS_LAST_PULSE);
  wire        dma_req = dma_in_req_in | dma_out_req_in;
  wire        int_ok = int_req_in & interrupt_enable_flag;

  function [15:0] ccs_step;
    input [15:0] v;
    input        down;
    begin
      ccs_step = down ? v - 16'h0001 : v + 16'h0001;
    end
  endfunction

  function [8:0] ccs_add;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    begin
      ccs_add = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
  endfunction

  function ccs_branch_ok;
    input [3:0] n;
    input [7:0] acc;
    input       c;
    input [3:0] fl;
    reg         t;
    begin
      t = 1'b0;
      case (n[1:0])
        2'h0: t = 1'b1;
        2'h1: t = 1'b0;
        2'h2: t = (acc == 8'h00);
        2'h3: t = c;
        default: t = 1'b0;
      endcase
      if (n[2]) begin
        t = fl[n[1:0]];
      end
      if (n[3] && n != 4'h8) begin
        t = ~t;
      end else if (n == 4'h8) begin
        t = 1'b0;
      end
      ccs_branch_ok = t;
    end
  endfunction

  ccs_reg_array u_regs (
    .mclk_in     (mclk_in),
    .resetn_in   (resetn_in),
    .rd_sel_in   (rd_sel),
    .wr_sel_in   (rd_sel),
    .wr_en_in    (wr_en),
    .wr_data_in  (wr_data),
    .rd_data_out (sel_reg)
  );

  assign memory_write_strobe_out = mem_wr && (pulse >= `CCS_WR_FIRST)
                                   && (pulse <= `CCS_WR_LAST);
  assign data_oe_out = mem_wr;
  assign mem_read_out = mem_rd;
  assign io_active_out = (state == ST_EXEC)
                         && (high_opcode_nibble == `CCS_OP_IO);
  assign dma_ack_out = (state == ST_DMA);
  assign int_ack_out = int_taken;
  assign cycle_state_out = state;
  assign pulse_out = pulse;
  assign accumulator_out = accumulator;
  assign carry_flag_out = carry_flag;
  assign interrupt_enable_flag_out = interrupt_enable_flag;
  assign saved_context_byte_out = saved_context_byte;

  // Register selection and memory direction per cycle and opcode group
  always @* begin
    rd_sel = pc_selector;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    case (state)
      ST_FETCH: begin
        rd_sel = pc_selector;
        mem_rd = 1'b1;
      end
      ST_DMA: begin
        rd_sel = `CCS_DMA_REG;
        mem_wr = dma_dir_in;
        mem_rd = ~dma_dir_in;
      end
      ST_EXEC: begin
        case (high_opcode_nibble)
          `CCS_OP_INC, `CCS_OP_DEC, `CCS_OP_GLO, `CCS_OP_GHI,
          `CCS_OP_PLO, `CCS_OP_PHI: rd_sel = low_opcode_nibble;
          `CCS_OP_LOAD: begin
            rd_sel = low_opcode_nibble;
            mem_rd = 1'b1;
          end
          `CCS_OP_STORE: begin
            rd_sel = low_opcode_nibble;
            mem_wr = 1'b1;
          end
          `CCS_OP_IO: begin
            rd_sel = pointer_selector;
            mem_wr = low_opcode_nibble[3];
            mem_rd = ~low_opcode_nibble[3];
          end
          `CCS_OP_CTRL: begin
            rd_sel = pointer_selector;
            mem_wr = (low_opcode_nibble == `CCS_SAVE_CODE);
            mem_rd = ~low_opcode_nibble[3];
          end
          `CCS_OP_BRANCH: begin
            rd_sel = pc_selector;
            mem_rd = 1'b1;
          end
          `CCS_OP_ALU: begin
            // Immediate forms read through the program counter
            rd_sel = low_opcode_nibble[3] ? pc_selector
                                          : pointer_selector;
            mem_rd = 1'b1;
          end
          default: rd_sel = pc_selector;
        endcase
      end
      default: rd_sel = pc_selector;
    endcase
  end

  // Write-back of the stepped or modified register, once at cycle end
  always @* begin
    wr_en = 1'b0;
    wr_data = sel_reg;
    if (last_pulse) begin
      case (state)
        ST_FETCH: begin
          wr_en = 1'b1;
          wr_data = ccs_step(sel_reg, 1'b0);
        end
        ST_DMA: begin
          wr_en = 1'b1;
          wr_data = ccs_step(sel_reg, 1'b0);
        end
        ST_EXEC: begin
          case (high_opcode_nibble)
            `CCS_OP_INC, `CCS_OP_LOAD: begin
              wr_en = 1'b1;
              wr_data = ccs_step(sel_reg, 1'b0);
            end
            `CCS_OP_DEC: begin
              wr_en = 1'b1;
              wr_data = ccs_step(sel_reg, 1'b1);
            end
            `CCS_OP_PLO: begin
              wr_en = 1'b1;
              wr_data = {sel_reg[15:8], accumulator};
            end
            `CCS_OP_PHI: begin
              wr_en = 1'b1;
              wr_data = {accumulator, sel_reg[7:0]};
            end
            `CCS_OP_IO: begin
              wr_en = ~low_opcode_nibble[3];
              wr_data = ccs_step(sel_reg, 1'b0);
            end
            `CCS_OP_CTRL: begin
              wr_en = ~low_opcode_nibble[3];
              wr_data = ccs_step(sel_reg, 1'b0);
            end
            `CCS_OP_ALU: begin
              wr_en = low_opcode_nibble[3];
              wr_data = ccs_step(sel_reg, 1'b0);
            end
            `CCS_OP_BRANCH: begin
              wr_en = 1'b1;
              wr_data = ccs_branch_ok(low_opcode_nibble, accumulator,
                                      carry_flag, ext_flags_in)
                        ? {sel_reg[15:8], data_in}
                        : ccs_step(sel_reg, 1'b0);
            end
            default: wr_en = 1'b0;
          endcase
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  // End-of-cycle arbitration: DMA first, then enabled interrupt
  always @* begin
    next_state = state;
    if (last_pulse) begin
      case (state)
        ST_FETCH: next_state = ST_EXEC;
        ST_EXEC, ST_DMA, ST_IDLE: begin
          if (dma_req) begin
            next_state = ST_DMA;
          end else if (state == ST_IDLE && !int_ok) begin
            next_state = ST_IDLE;
          end else if (state == ST_EXEC && high_opcode_nibble == `CCS_OP_IDLE
                       && low_opcode_nibble == 4'h0 && !int_ok) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_FETCH;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Only edge-triggered flops; the clock may stop anywhere safely
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      pulse <= 3'h0;
      pc_selector <= 4'h0;
      pointer_selector <= 4'h0;
      interrupt_enable_flag <= 1'b1;
      high_opcode_nibble <= 4'h0;
      low_opcode_nibble <= 4'h0;
      accumulator <= 8'h00;
      carry_flag <= 1'b0;
      saved_context_byte <= 8'h00;
      dma_dir_in <= 1'b0;
      int_taken <= 1'b0;
      addr_out <= 8'h00;
      data_out <= 8'h00;
      io_cmd_out <= 4'h0;
    end else begin
      pulse <= pulse + 3'h1;
      state <= next_state;
      int_taken <= 1'b0;
      // Upper byte on the early pulses, lower byte after
      addr_out <= (pulse < `CCS_ADDR_HI_PULSES) ? sel_reg[15:8]
                                                : sel_reg[7:0];
      io_cmd_out <= (state == ST_EXEC && high_opcode_nibble == `CCS_OP_IO)
                    ? low_opcode_nibble : 4'h0;
      if (state == ST_EXEC && high_opcode_nibble == `CCS_OP_CTRL
          && low_opcode_nibble == `CCS_SAVE_CODE) begin
        data_out <= saved_context_byte;
      end else begin
        data_out <= accumulator;
      end
      if (last_pulse && (state != ST_FETCH) && dma_req) begin
        dma_dir_in <= dma_in_req_in;
      end
      if (last_pulse && state == ST_FETCH) begin
        high_opcode_nibble <= data_in[7:4];
        low_opcode_nibble <= data_in[3:0];
      end
      if (last_pulse && state == ST_EXEC) begin
        case (high_opcode_nibble)
          `CCS_OP_LOAD: accumulator <= data_in;
          `CCS_OP_GLO: accumulator <= sel_reg[7:0];
          `CCS_OP_GHI: accumulator <= sel_reg[15:8];
          `CCS_OP_IO: begin
            if (low_opcode_nibble[3]) begin
              accumulator <= data_in;
            end
          end
          `CCS_OP_SETPC: pc_selector <= low_opcode_nibble;
          `CCS_OP_SETPTR: pointer_selector <= low_opcode_nibble;
          `CCS_OP_CTRL: begin
            if (low_opcode_nibble[3:1] == 3'h0) begin
              pointer_selector <= data_in[7:4];
              pc_selector <= data_in[3:0];
              interrupt_enable_flag <= ~low_opcode_nibble[0];
            end
          end
          `CCS_OP_ALU: begin
            case (low_opcode_nibble[2:0])
              3'h0: accumulator <= data_in;
              3'h1: accumulator <= data_in | accumulator;
              3'h2: accumulator <= data_in & accumulator;
              3'h3: accumulator <= data_in ^ accumulator;
              3'h4: {carry_flag, accumulator} <=
                      ccs_add(data_in, accumulator, 1'b0);
              3'h5: {carry_flag, accumulator} <=
                      ccs_add(data_in, ~accumulator, 1'b1);
              3'h6: begin
                carry_flag <= accumulator[0];
                accumulator <= {1'b0, accumulator[7:1]};
              end
              3'h7: {carry_flag, accumulator} <=
                      ccs_add(accumulator, ~data_in, 1'b1);
              default: accumulator <= accumulator;
            endcase
          end
          default: accumulator <= accumulator;
        endcase
      end
      // Interrupt entry replaces any selector change made above
      if (last_pulse && state != ST_FETCH && !dma_req && int_ok) begin
        saved_context_byte <= {pointer_selector, pc_selector};
        pointer_selector <= `CCS_INT_PTR_SEL;
        pc_selector <= `CCS_INT_PC_SEL;
        interrupt_enable_flag <= 1'b0;
        int_taken <= 1'b1;
      end
    end
  end
endmodule

// ---- tb/ccs_seq_properties.sv ----
// Port timing checker for the cycle sequencer
`timescale 1ns/1ps
`include "ccs_defs.vh"
module ccs_seq_properties (
  input wire       mclk_in,
  input wire       resetn_in,
  input wire       dma_in_req_in,
  input wire       dma_out_req_in,
  input wire       memory_write_strobe_out,
  input wire       data_oe_out,
  input wire       dma_ack_out,
  input wire       int_ack_out,
  input wire [1:0] cycle_state_out,
  input wire [2:0] pulse_out,
  input wire       interrupt_enable_flag_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire dreq = dma_in_req_in | dma_out_req_in;
  wire end7 = pulse_out == `CCS_LAST_PULSE;
  wire wr   = memory_write_strobe_out;
  a_pulse_wrap: assert property (end7 |=> pulse_out == 3'h0)
    else $error("pulse count did not wrap");
  a_pulse_step: assert property
    (!end7 |=> pulse_out == $past(pulse_out) + 3'h1)
    else $error("pulse count skipped");
  a_state_hold: assert property (!end7 |=> $stable(cycle_state_out))
    else $error("cycle changed mid cycle");
  a_fetch_exec: assert property
    (cycle_state_out == `CCS_ST_FETCH && end7 |=>
     cycle_state_out == `CCS_ST_EXEC)
    else $error("fetch not followed by execute");
  a_dma_first: assert property
    (end7 && dreq && cycle_state_out != `CCS_ST_FETCH |=>
     cycle_state_out == `CCS_ST_DMA && !int_ack_out)
    else $error("request did not steal a cycle");
  a_dma_ack: assert property
    ($rose(dma_ack_out) |->
     (dma_ack_out && cycle_state_out == `CCS_ST_DMA) [*8])
    else $error("stolen cycle not acknowledged");
  a_strobe_window: assert property
    (wr |-> data_oe_out && pulse_out inside {`CCS_WR_FIRST, `CCS_WR_LAST})
    else $error("write strobe outside its window");
  a_strobe_len: assert property ($rose(wr) |-> ##1 wr ##1 !wr)
    else $error("write strobe length wrong");
  a_int_entry: assert property
    (int_ack_out |=> !int_ack_out && !interrupt_enable_flag_out)
    else $error("interrupt entry left enable set");
  a_int_masked: assert property
    (end7 && !interrupt_enable_flag_out |=> !int_ack_out [*2])
    else $error("interrupt taken while disabled");
  cover property (cycle_state_out == `CCS_ST_DMA && end7);
  cover property ($rose(int_ack_out));
  cover property ($rose(wr));
endmodule

// ---- tb/ccs_mem_model.sv ----
// Behavioural byte memory on the far side of the sequencer bus
`timescale 1ns/1ps
module ccs_mem_model (
  input  wire       mclk_in,
  input  wire [7:0] addr_in,
  input  wire [2:0] pulse_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_strobe_in,
  input  wire       rd_in,
  output wire [7:0] rdata_out
);
  reg [7:0]  mem [0:65535];
  reg [15:0] addr;
  reg [7:0]  last;
  reg [15:0] log_addr [0:7];
  reg [7:0]  log_data [0:7];
  integer    n_wr;
  integer    i;
  // Released bus shows inverse of last byte, never a stale copy
  assign rdata_out = rd_in ? mem[addr] : ~last;
  initial begin
    n_wr = 0;
    last = 8'h00;
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = 8'h00;
  end
  // Upper byte first, then lower
  always @(posedge mclk_in) begin
    if (pulse_in == 3'h2)
      addr[15:8] <= addr_in;
    if (pulse_in == 3'h4)
      addr[7:0] <= addr_in;
    if (rd_in)
      last <= mem[addr];
    if (wr_strobe_in && pulse_in == 3'h6) begin
      mem[addr] <= wdata_in;
      log_addr[n_wr[2:0]] <= addr;
      log_data[n_wr[2:0]] <= wdata_in;
      n_wr <= n_wr + 1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Directed bench for the cycle sequencer with a memory model
`timescale 1ns/1ps
`include "ccs_defs.vh"
module testbench;
  reg         mclk_in;
  reg         resetn_in;
  reg         dma_in_req, dma_out_req, int_req;
  wire [7:0]  addr, dout, din, acc, saved;
  wire [3:0]  io_cmd;
  wire [1:0]  state;
  wire [2:0]  pulse;
  wire        oe, wr, rd, io_act, dack, iack, carry, ie;
  integer     n_fail, n_checks, i, k;
  reg [15:0]  a;
  reg [71:0]  prog;
  reg [7:0]   last_fetch;
  ccs_sequencer DUT (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .data_in(din), .dma_in_req_in(dma_in_req), .dma_out_req_in(dma_out_req),
    .int_req_in(int_req), .ext_flags_in(4'h0), .addr_out(addr),
    .data_out(dout), .data_oe_out(oe), .memory_write_strobe_out(wr),
    .mem_read_out(rd), .io_cmd_out(io_cmd), .io_active_out(io_act),
    .dma_ack_out(dack), .int_ack_out(iack), .cycle_state_out(state),
    .pulse_out(pulse), .accumulator_out(acc), .carry_flag_out(carry),
    .interrupt_enable_flag_out(ie), .saved_context_byte_out(saved));
  ccs_mem_model mem (.mclk_in(mclk_in), .addr_in(addr), .pulse_in(pulse),
    .wdata_in(dout), .wr_strobe_in(wr), .rd_in(rd), .rdata_out(din));
  always #20 mclk_in = ~mclk_in;
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task till_pulse(input [2:0] p);
    begin
      // Returns at once when already at that pulse
      k = 0;
      while (pulse !== p && k < 16) begin
        @(negedge mclk_in);
        k = k + 1;
      end
    end
  endtask
  task get_addr;
    begin
      till_pulse(3'h2);
      a[15:8] = addr;
      till_pulse(3'h5);
      a[7:0] = addr;
    end
  endtask
  // DMA requests stand through pulse 7 only, so stealing is one cycle each; int_req is held
  task request(input di, input dq, input irq);
    begin
      till_pulse(3'h7);
      dma_in_req = di;
      dma_out_req = dq;
      int_req = irq;
      @(negedge mclk_in);
      dma_in_req = 1'b0;
      dma_out_req = 1'b0;
    end
  endtask
  task give_verdict;
    begin
      if (n_fail == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #(2000 * 40);
    n_fail = n_fail + 1;
    give_verdict;
  end
  initial begin
    n_fail = 0;
    n_checks = 0;
    mclk_in = 1'b0;
    resetn_in = 1'b0;
    dma_in_req = 1'b0;
    dma_out_req = 1'b0;
    int_req = 1'b0;
    prog = 72'hF8_80_A2_78_52_61_FC_80_D2;
    repeat (3) @(negedge mclk_in);
    check(ie, 1'b1);
    check(acc, 8'h00);
    resetn_in = 1'b1;
    repeat (12) @(negedge mclk_in);
    check(state, `CCS_ST_IDLE);
    request(1'b0, 1'b1, 1'b0);
    check(dack, 1'b1);
    get_addr;
    check(a, 16'h0000);
    request(1'b1, 1'b0, 1'b0);
    get_addr;
    check(a, 16'h0001);
    till_pulse(3'h7);
    for (i = 0; i < 9; i = i + 1)
      mem.mem[i] = prog[71 - 8 * i -: 8];
    // DMA and interrupt raised together
    request(1'b0, 1'b1, 1'b1);
    get_addr;
    check(state, `CCS_ST_DMA);
    check(a, 16'h0002);
    k = 0;
    while (iack !== 1'b1 && k < 40) begin
      @(negedge mclk_in);
      k = k + 1;
    end
    int_req = 1'b0;
    check(iack, 1'b1);
    check(saved, 8'h00);
    k = 0;
    while (!(io_act === 1'b1 && pulse === 3'h4) && k < 400) begin
      @(negedge mclk_in);
      k = k + 1;
    end
    check(io_cmd, 4'h1);
    check(addr, 8'h80);
    check(acc, 8'h80);
    check(mem.n_wr, 3);
    check(mem.log_addr[0], 16'h0001);
    check(mem.log_addr[1], 16'h0080);
    check(mem.log_data[1], 8'h00);
    check(mem.log_addr[2], 16'h0080);
    check(mem.log_data[2], 8'h80);
    // Enable now clear: a held request must be ignored
    int_req = 1'b1;
    a = 16'h0000;
    last_fetch = 8'h00;
    repeat (60) begin
      @(negedge mclk_in);
      if (iack === 1'b1)
        a = a + 16'h1;
      if (state === `CCS_ST_FETCH && pulse === 3'h5)
        last_fetch = addr;
    end
    int_req = 1'b0;
    check(a, 16'h0000);
    check(ie, 1'b0);
    check(carry, 1'b1);
    check(acc, 8'h00);
    check(last_fetch, 8'h81);
    check(state, `CCS_ST_IDLE);
    give_verdict;
  end
endmodule
bind ccs_sequencer ccs_seq_properties u_props (.mclk_in, .resetn_in,
  .dma_in_req_in, .dma_out_req_in, .memory_write_strobe_out, .data_oe_out,
  .dma_ack_out, .int_ack_out, .cycle_state_out, .pulse_out,
  .interrupt_enable_flag_out);
